/* File: agoa_pkg.sv */
// agoa_pkg: constants, encodings and carriers of the ALU group decoder
// assumes a single core clock; shared by agoa_top and agoa_resolve
package agoa_pkg;
  // apb byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SLOT_LO = 8'h04;
  localparam logic [7:0] OFF_SLOT_HI = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PREV = 8'h10;
  localparam logic [7:0] OFF_AIDX = 8'h20;
  // control and status fields, reset values
  localparam int CTRL_GREGS_LSB = 0;
  localparam int CTRL_TEMPS_LSB = 8;
  localparam int CTRL_MEMRD_BIT = 16;
  localparam int STAT_DUP_BIT = 8;
  localparam int STAT_FAULT_BIT = 9;
  localparam logic [7:0] GREGS_RST = 8'h80;
  localparam logic [7:0] TEMPS_RST = 8'h00;
  // instruction slot fields
  localparam int SRC_SEL_LSB [3] = '{0, 13, 32};
  localparam int SOURCE_RELATIVE_FLAG_BIT [3] = '{9, 22, 41};
  localparam int SRC_ELEM_LSB [3] = '{10, 23, 42};
  localparam int IDX_MODE_LSB = 26;
  localparam int LAST_BIT = 31;
  localparam int OPC_MSB = 49;
  localparam int OPC2_W = 10;
  localparam int OPC3_W = 5;
  localparam int DST_REG_LSB = 53;
  localparam int DEST_RELATIVE_FLAG_BIT = 60;
  localparam int DST_ELEM_LSB = 61;
  // source select encodings
  localparam logic [8:0] SEL_KC0 = 9'h080;
  localparam logic [8:0] SEL_KC1 = 9'h0A0;
  localparam logic [8:0] SEL_KC_END = 9'h0C0;
  localparam logic [8:0] SEL_LIT = 9'h0FD;
  localparam logic [8:0] SEL_PREV = 9'h0FE;
  localparam logic [8:0] SEL_CREG = 9'h100;
  localparam logic [9:0] REG_TOP = 10'h080;
  localparam logic [8:0] CREG_MAX = 9'h0FF;
  localparam logic [4:0] KC_LIM1 = 5'h0F;
  localparam logic [4:0] KC_LIM2 = 5'h1F;
  localparam logic [31:0] NAN_VAL = 32'h7FFFFFFF;
  // opcode values of the no-operation and load-index ops, arbitrary
  localparam logic [9:0] NOP_OPC = 10'h01A;
  localparam logic [9:0] LOAD_INDEX_OPC = 10'h015;

  typedef enum logic [2:0] {
    INDEX_BY_ELEMENT_X = 3'b000, INDEX_BY_ELEMENT_Y = 3'b001,
    INDEX_BY_ELEMENT_Z = 3'b010, INDEX_BY_ELEMENT_W = 3'b011,
    INDEX_LOOP = 3'b100
  } agoa_idx_t;
  typedef enum logic [1:0] {
    CONST_CACHE_UNLOCKED = 2'b00, CONST_CACHE_LOCK1 = 2'b01, CONST_CACHE_LOCK2 = 2'b10
  } agoa_kc_t;
  typedef enum logic [2:0] {
    OK_GREG = 3'b000, OK_TEMP = 3'b001, OK_CREG = 3'b010, OK_KC0 = 3'b011,
    OK_KC1 = 3'b100, OK_LIT = 3'b101, OK_PREVV = 3'b110, OK_OTHER = 3'b111
  } agoa_kind_t;
  typedef enum logic [1:0] {
    ACT_NORMAL = 2'b00, ACT_REG0 = 2'b01, ACT_NAN = 2'b10, ACT_SUPPRESS = 2'b11
  } agoa_act_t;
  typedef enum logic [1:0] {
    PH_INST = 2'b00, PH_LIT = 2'b01, PH_COMMIT = 2'b10
  } agoa_phase_t;

  typedef struct packed {
    agoa_kind_t kind;
    logic [8:0] addr;
    agoa_act_t act;
    logic [1:0] elem;
  } agoa_opnd_t;
  typedef struct packed {
    logic valid;
    logic op3;
    logic [9:0] opcode;
    logic load_index;
    agoa_opnd_t [3:0] opnd;
  } agoa_chan_t;
  typedef struct packed {
    agoa_chan_t [3:0] chan;
    logic [3:0][31:0] literal;
    logic [2:0] slots;
  } agoa_group_t;
endpackage : agoa_pkg

/* File: agoa_resolve.sv */
// agoa_resolve: resolves one operand select into kind, address and action
// assumes index values already captured; purely combinational
`timescale 1ns/1ps
module agoa_resolve #(
  parameter bit IS_DEST = 1'b0
) (
  // operand fields
  input wire logic [8:0] sel,
  input wire logic rel,
  input wire logic [1:0] elem,
  input wire agoa_pkg::agoa_idx_t mode,
  // index sources and limits
  input wire logic [3:0][31:0] aidx,
  input wire logic [31:0] loop_idx,
  input wire logic [7:0] greg_count,
  input wire logic [7:0] temp_count,
  input wire agoa_pkg::agoa_kc_t kc_mode,
  input wire logic mem_read,
  // result
  output var agoa_pkg::agoa_opnd_t res
);
  logic signed [33:0] idx;
  logic signed [33:0] sum;
  logic [8:0] off;

  // index choice by operand type, then bounds
  always_comb begin
    idx = '0;
    off = sel;
    res = '{kind: agoa_pkg::OK_OTHER, addr: sel, act: agoa_pkg::ACT_NORMAL, elem: elem};
    if (sel < agoa_pkg::SEL_KC0) begin
      idx = (mode == agoa_pkg::INDEX_LOOP) ? {{2{loop_idx[31]}}, loop_idx}
                                           : {{2{aidx[0][31]}}, aidx[0]};
    end else if (sel < agoa_pkg::SEL_KC_END) begin
      idx = {{2{loop_idx[31]}}, loop_idx};
      off = sel - ((sel < agoa_pkg::SEL_KC1) ? agoa_pkg::SEL_KC0 : agoa_pkg::SEL_KC1);
    end else if (sel >= agoa_pkg::SEL_CREG) begin
      off = {1'b0, sel[7:0]};
      idx = (mode == agoa_pkg::INDEX_LOOP) ? {{2{loop_idx[31]}}, loop_idx}
                                           : {{2{aidx[mode[1:0]][31]}}, aidx[mode[1:0]]};
    end
    sum = $signed({25'h0, off}) + (rel ? idx : 34'sh0);
    res.addr = sum[8:0];
    if (sel < agoa_pkg::SEL_KC0) begin
      // top temp_count registers up to 127 are clause temporaries
      if (temp_count != 8'h00 && ({1'b0, sel} + {2'h0, temp_count}) >= agoa_pkg::REG_TOP)
        res.kind = agoa_pkg::OK_TEMP;
      else
        res.kind = agoa_pkg::OK_GREG;
      if (rel && res.kind == agoa_pkg::OK_GREG &&
          (sum < 0 || sum >= $signed({26'h0, greg_count}))) begin
        res.addr = '0;
        if (!IS_DEST)
          res.act = agoa_pkg::ACT_REG0;
        else
          res.act = mem_read ? agoa_pkg::ACT_REG0 : agoa_pkg::ACT_SUPPRESS;
      end
    end else if (sel < agoa_pkg::SEL_KC_END) begin
      res.kind = (sel < agoa_pkg::SEL_KC1) ? agoa_pkg::OK_KC0 : agoa_pkg::OK_KC1;
      if (rel && (sum < 0 || sum > $signed({29'h0, (kc_mode == agoa_pkg::CONST_CACHE_LOCK2)
          ? agoa_pkg::KC_LIM2 : agoa_pkg::KC_LIM1})))
        res.act = agoa_pkg::ACT_NAN;
    end else if (sel >= agoa_pkg::SEL_CREG) begin
      res.kind = agoa_pkg::OK_CREG;
      if (rel && (sum < 0 || sum > $signed({25'h0, agoa_pkg::CREG_MAX})))
        res.act = agoa_pkg::ACT_NAN;
    end else if (sel == agoa_pkg::SEL_LIT) begin
      res.kind = agoa_pkg::OK_LIT;
    end else if (sel == agoa_pkg::SEL_PREV) begin
      res.kind = agoa_pkg::OK_PREVV;
    end
  end
endmodule : agoa_resolve

/* File: agoa_top.sv */
// agoa_top: assembles ALU instruction groups, resolves operands, keeps
// the previous-result vector and the address-index register
// assumes an apb master for slots and config, a sequencer for clause marks
//
// Behaviour
// - slots 0..3 hold one 64-bit instruction each for channels X..W
// - literal slot one gives X then Y, slot two gives Z then W
// - a group spans one to six 64-bit slots
// - destination channel picks the slot; issuer sends one per channel
// - empty channel slots decode as no-operation
// - previous-result vector holds four 32-bit results of the last group
// - no-operation and clause start both clear previous results
// - two-source format has 10-bit opcode field, top three bits zero
// - three-source format uses 5-bit opcode, top three bits nonzero
// - top N registers ending at 127 are clause temporaries
// - register index is loop or index X; constants may use any index element
// - one index per instruction, relative flag per operand and destination
// - out-of-range relative register read returns register zero
// - out-of-range relative write is dropped, memory reads go to register zero
// - relative constant read outside 0..255 gives 0x7FFFFFFF
// - relative cache read outside locked range gives 0x7FFFFFFF
// - group-end flag on last instruction delimits groups
// - one literal slot for X/Y references, two for Z/W
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
module agoa_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sequencer side
  input wire logic clause_start,
  input wire agoa_pkg::agoa_kc_t kc_mode,
  input wire logic [31:0] loop_counter_index,
  // channel units
  input wire logic result_valid,
  input wire logic [3:0][31:0] result,
  output logic grp_valid,
  output agoa_pkg::agoa_group_t grp,
  output logic [3:0][31:0] previous_result_vector
);
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] greg_count;
    logic [7:0] temp_count;
    logic mem_read;
    logic [31:0] slot_lo;
    agoa_pkg::agoa_phase_t phase;
    logic [3:0][63:0] inst;
    logic [3:0] ivalid;
    logic [2:0] icnt;
    logic [1:0][63:0] lit;
    logic [1:0] lneed;
    logic lcnt;
    logic grp_valid;
    agoa_pkg::agoa_group_t grp;
    logic [3:0] live;
    logic [3:0] lidx;
    logic [3:0][31:0] prev;
    logic [3:0][31:0] aidx;
    logic aidx_valid;
    logic dup_err;
    logic idx_fault;
  } agoa_state_t;

  agoa_state_t r;
  agoa_state_t n;
  logic acc;
  logic push;
  logic [63:0] slot;
  logic [1:0] slot_need;
  logic [1:0] tot_need;
  logic [3:0] op3;
  logic [3:0] nopc;
  logic [3:0] uses_aidx;
  logic [3:0][2:0] cmode;
  agoa_pkg::agoa_opnd_t [3:0][3:0] res;

  // literal slots one instruction asks for
  function automatic logic [1:0] lit_need(input logic [63:0] s);
    logic [1:0] nd;
    nd = 2'h0;
    for (int k = 0; k < 3; k++) begin
      if ((k < 2 || s[agoa_pkg::OPC_MSB -: 3] != 3'h0) &&
          s[agoa_pkg::SRC_SEL_LSB[k] +: 9] == agoa_pkg::SEL_LIT) begin
        if (s[agoa_pkg::SRC_ELEM_LSB[k] + 1])
          nd = 2'h2;
        else if (nd == 2'h0)
          nd = 2'h1;
      end
    end
    return nd;
  endfunction : lit_need

  ////////////////////////////////////////////////////////////////////////
  // apb access strobes and slot pushes
  assign acc = psel & penable & ~r.pready;
  assign push = acc & pwrite & (paddr == agoa_pkg::OFF_SLOT_HI);
  assign slot = {pwdata, r.slot_lo};
  assign slot_need = lit_need(slot);
  assign tot_need = (slot_need > r.lneed) ? slot_need : r.lneed;

  ////////////////////////////////////////////////////////////////////////
  // per channel decode and operand resolution
  for (genvar c = 0; c < 4; c++) begin : g_chan
    // nonzero top bits mark the three-source format
    assign op3[c] = r.inst[c][agoa_pkg::OPC_MSB -: 3] != 3'h0;
    assign nopc[c] = !r.ivalid[c] ||
      (!op3[c] && r.inst[c][agoa_pkg::OPC_MSB -: agoa_pkg::OPC2_W] == agoa_pkg::NOP_OPC);
    assign cmode[c] = r.inst[c][agoa_pkg::IDX_MODE_LSB +: 3];
    assign uses_aidx[c] = r.ivalid[c] && cmode[c] != agoa_pkg::INDEX_LOOP &&
      (r.inst[c][agoa_pkg::SOURCE_RELATIVE_FLAG_BIT[0]] || r.inst[c][agoa_pkg::SOURCE_RELATIVE_FLAG_BIT[1]] ||
       r.inst[c][agoa_pkg::DEST_RELATIVE_FLAG_BIT] || (op3[c] && r.inst[c][agoa_pkg::SOURCE_RELATIVE_FLAG_BIT[2]]));
    for (genvar k = 0; k < 4; k++) begin : g_opnd
      if (k < 3) begin : g_src
        agoa_resolve #(.IS_DEST(1'b0)) u_res (
          .sel(r.inst[c][agoa_pkg::SRC_SEL_LSB[k] +: 9]),
          .rel(r.inst[c][agoa_pkg::SOURCE_RELATIVE_FLAG_BIT[k]]),
          .elem(r.inst[c][agoa_pkg::SRC_ELEM_LSB[k] +: 2]),
          .mode(agoa_pkg::agoa_idx_t'(cmode[c])),
          .aidx(r.aidx),
          .loop_idx(loop_counter_index),
          .greg_count(r.greg_count),
          .temp_count(r.temp_count),
          .kc_mode(kc_mode),
          .mem_read(r.mem_read),
          .res(res[c][k])
        );
      end else begin : g_dst
        agoa_resolve #(.IS_DEST(1'b1)) u_res (
          .sel({2'h0, r.inst[c][agoa_pkg::DST_REG_LSB +: 7]}),
          .rel(r.inst[c][agoa_pkg::DEST_RELATIVE_FLAG_BIT]),
          .elem(r.inst[c][agoa_pkg::DST_ELEM_LSB +: 2]),
          .mode(agoa_pkg::agoa_idx_t'(cmode[c])),
          .aidx(r.aidx),
          .loop_idx(loop_counter_index),
          .greg_count(r.greg_count),
          .temp_count(r.temp_count),
          .kc_mode(kc_mode),
          .mem_read(r.mem_read),
          .res(res[c][k])
        );
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state: bus, assembly, commit, results
  always_comb begin
    n = r;
    n.grp_valid = 1'b0;
    n.pready = acc; // answer on the second access cycle
    n.pslverr = 1'b0;
    n.prdata = '0;
    if (acc) begin
      case (paddr)
        agoa_pkg::OFF_CTRL: begin
          n.prdata = {15'h0, r.mem_read, r.temp_count, r.greg_count};
          if (pwrite) begin
            n.greg_count = pwdata[agoa_pkg::CTRL_GREGS_LSB +: 8];
            n.temp_count = pwdata[agoa_pkg::CTRL_TEMPS_LSB +: 8];
            n.mem_read = pwdata[agoa_pkg::CTRL_MEMRD_BIT];
          end
        end
        agoa_pkg::OFF_SLOT_LO: begin
          n.prdata = r.slot_lo;
          if (pwrite)
            n.slot_lo = pwdata;
        end
        agoa_pkg::OFF_SLOT_HI: n.prdata = '0;
        agoa_pkg::OFF_STATUS: begin
          n.prdata = {22'h0, r.idx_fault, r.dup_err, 2'h0, r.phase, r.aidx_valid,
                      r.grp.slots};
          // write one to clear; a set in this cycle still wins below
          if (pwrite && pwdata[agoa_pkg::STAT_DUP_BIT])
            n.dup_err = 1'b0;
          if (pwrite && pwdata[agoa_pkg::STAT_FAULT_BIT])
            n.idx_fault = 1'b0;
        end
        default: begin
          if (paddr[7:4] == agoa_pkg::OFF_PREV[7:4])
            n.prdata = r.prev[paddr[3:2]];
          else if (paddr[7:4] == agoa_pkg::OFF_AIDX[7:4])
            n.prdata = r.aidx[paddr[3:2]];
          else
            n.pslverr = 1'b1;
        end
      endcase
    end

    // group assembly; group-end flag closes the instruction part
    case (r.phase)
      agoa_pkg::PH_INST: begin
        if (push) begin
          // channel comes from the destination element
          if (r.ivalid[slot[agoa_pkg::DST_ELEM_LSB +: 2]])
            n.dup_err = 1'b1;
          n.inst[slot[agoa_pkg::DST_ELEM_LSB +: 2]] = slot;
          n.ivalid[slot[agoa_pkg::DST_ELEM_LSB +: 2]] = 1'b1;
          if (!r.ivalid[slot[agoa_pkg::DST_ELEM_LSB +: 2]])
            n.icnt = r.icnt + 3'h1;
          n.lneed = tot_need;
          if (slot[agoa_pkg::LAST_BIT])
            n.phase = (tot_need == 2'h0) ? agoa_pkg::PH_COMMIT : agoa_pkg::PH_LIT;
        end
      end
      agoa_pkg::PH_LIT: begin
        if (push) begin
          // first literal slot always precedes the second
          n.lit[r.lcnt] = slot;
          n.lcnt = 1'b1;
          if ({1'b0, r.lcnt} + 2'h1 == r.lneed)
            n.phase = agoa_pkg::PH_COMMIT;
        end
      end
      agoa_pkg::PH_COMMIT: begin
        n.grp_valid = 1'b1;
        for (int c = 0; c < 4; c++) begin
          n.grp.chan[c].valid = r.ivalid[c];
          n.grp.chan[c].op3 = r.ivalid[c] && op3[c];
          n.grp.chan[c].opcode = nopc[c] ? agoa_pkg::NOP_OPC :
            (op3[c] ? {r.inst[c][agoa_pkg::OPC_MSB -: agoa_pkg::OPC3_W], 5'h00}
                    : r.inst[c][agoa_pkg::OPC_MSB -: agoa_pkg::OPC2_W]);
          n.grp.chan[c].load_index = !nopc[c] && !op3[c] &&
            r.inst[c][agoa_pkg::OPC_MSB -: agoa_pkg::OPC2_W] == agoa_pkg::LOAD_INDEX_OPC;
          for (int k = 0; k < 4; k++) begin
            n.grp.chan[c].opnd[k] = res[c][k];
            if (nopc[c] || (k == 2 && !op3[c]))
              n.grp.chan[c].opnd[k] = '{kind: agoa_pkg::OK_OTHER, addr: 9'h000,
                                        act: agoa_pkg::ACT_NORMAL, elem: 2'h0};
          end
          n.live[c] = !nopc[c];
          n.lidx[c] = n.grp.chan[c].load_index;
        end
        // literal dwords in X, Y, Z, W order
        n.grp.literal = {r.lit[1][63:32], r.lit[1][31:0], r.lit[0][63:32], r.lit[0][31:0]};
        n.grp.slots = r.icnt + {1'b0, r.lneed};
        // issuer misuse of the index register is flagged, not corrected
        if ((|uses_aidx) && (!r.aidx_valid || (|n.lidx)))
          n.idx_fault = 1'b1;
        for (int c = 1; c < 4; c++)
          if (uses_aidx[c] && uses_aidx[0] && cmode[c] != cmode[0])
            n.idx_fault = 1'b1;
        n.ivalid = '0;
        n.icnt = '0;
        n.lneed = '0;
        n.lcnt = 1'b0;
        n.phase = agoa_pkg::PH_INST;
      end
      default: n.phase = agoa_pkg::PH_INST;
    endcase

    // results of the last group; clause start takes precedence
    if (clause_start) begin
      n.prev = '0;
      n.aidx = '0;
      n.aidx_valid = 1'b0;
      n.live = '0;
      n.lidx = '0;
    end else if (result_valid) begin
      for (int c = 0; c < 4; c++) begin
        n.prev[c] = r.live[c] ? result[c] : 32'h0;
        if (r.lidx[c]) begin
          n.aidx[c] = result[c];
          n.aidx_valid = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.greg_count <= agoa_pkg::GREGS_RST;
      r.temp_count <= agoa_pkg::TEMPS_RST;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign grp_valid = r.grp_valid;
  assign grp = r.grp;
  assign previous_result_vector = r.prev;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_apb_answer: assert property ( // bus timing
    psel && penable && !pready |=> pready)
    else $error("apb access not answered on next cycle");

  chk_group_end_commit: assert property (
    push && r.phase == agoa_pkg::PH_INST && slot[agoa_pkg::LAST_BIT] && tot_need == 2'h0
    |-> !grp_valid ##2 grp_valid)
    else $error("group end did not commit the group two cycles later");

  chk_clause_clear: assert property (
    clause_start |=> previous_result_vector == '0 && !r.aidx_valid)
    else $error("clause start did not clear previous results and index");

  chk_prev_nop_clear: assert property (
    result_valid && !clause_start && !r.live[2] |=> previous_result_vector[2] == 32'h0)
    else $error("no-operation channel kept its previous result");

  chk_prev_capture: assert property (
    result_valid && !clause_start && r.live[1]
    |=> previous_result_vector[1] == $past(result[1]))
    else $error("previous result not captured from channel unit");

  chk_slot_count: assert property (
    grp_valid |-> grp.slots inside {[3'h1:3'h6]})
    else $error("group length outside one to six slots");

  chk_two_src_opcode: assert property (
    grp_valid && grp.chan[0].valid && !grp.chan[0].op3 |-> grp.chan[0].opcode[9:7] == 3'h0)
    else $error("two-source opcode with nonzero top bits");

  chk_empty_nop: assert property (
    grp_valid && !grp.chan[3].valid
    |-> grp.chan[3].opcode == agoa_pkg::NOP_OPC && $past(r.ivalid[3]) == 1'b0)
    else $error("empty channel slot not decoded as no-operation");

  chk_reg_oob_read: assert property (
    grp_valid && grp.chan[0].opnd[0].kind == agoa_pkg::OK_GREG &&
    grp.chan[0].opnd[0].act == agoa_pkg::ACT_REG0 |-> grp.chan[0].opnd[0].addr == 9'h000)
    else $error("out-of-range register read not redirected to register zero");

  chk_lit_wait: assert property (
    push && r.phase == agoa_pkg::PH_INST && slot[agoa_pkg::LAST_BIT] && tot_need == 2'h2
    |=> r.phase == agoa_pkg::PH_LIT && r.lneed == 2'h2)
    else $error("z or w literal reference did not wait for two literal slots");

  cov_full_group: cover property (grp_valid && grp.slots == 3'h6);
  cov_lit_one: cover property (grp_valid && grp.slots == 3'h2 && grp.chan[0].valid);
  cov_dup_channel: cover property (push && r.phase == agoa_pkg::PH_INST &&
                                   r.ivalid[slot[agoa_pkg::DST_ELEM_LSB +: 2]]);
  cov_index_load: cover property (result_valid && |r.lidx);
endmodule : agoa_top

/* File: agoa_seq_model.sv */
// agoa_seq_model: clause sequencer and channel units facing agoa_top
// assumes the bench gives clause, lock and loop requests at pclk edges
`timescale 1ns/1ps
module agoa_seq_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench requests and the decoder's group valid
  input wire logic cl_req,
  input wire agoa_pkg::agoa_kc_t kc_req,
  input wire logic [31:0] lp_req,
  input wire logic grp_valid,
  // toward the decoder
  output logic clause_start,
  output agoa_pkg::agoa_kc_t kc_mode,
  output logic [31:0] loop_counter_index,
  output logic result_valid,
  output logic [3:0][31:0] result
);
  // fixed per-channel results keep expectations simple
  assign result = {32'h000000A3, 32'h000000A2, 32'h000000A1, 32'h000000A0};
  ////////////////////////////////////////////////////////////////////
  // lock mode follows kc_req one cycle later at every edge, index only via loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clause_start <= 1'b1;
      kc_mode <= agoa_pkg::CONST_CACHE_UNLOCKED;
      loop_counter_index <= 32'h00000000;
      result_valid <= 1'b0;
    end else begin
      clause_start <= cl_req;
      kc_mode <= kc_req;
      loop_counter_index <= lp_req;
      result_valid <= grp_valid;
    end
  end
endmodule : agoa_seq_model

/* File: tb_top.sv */
// tb_top: apb-driven checks of group assembly and operand resolution
// assumes agoa_top and agoa_seq_model; pclk at 125 MHz
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, clause_start, result_valid, grp_valid, cl_req = 1'b0;
  logic [31:0] lp_req = 32'h00000008;
  logic [31:0] loop_counter_index;
  logic [3:0][31:0] result, pv;
  agoa_pkg::agoa_kc_t kc_req = agoa_pkg::CONST_CACHE_LOCK1;
  agoa_pkg::agoa_kc_t kc_mode;
  agoa_pkg::agoa_group_t grp;
  int err_total = 0;
  int check_count = 0;
  // clock
  always #4 pclk = ~pclk;
  agoa_top agoa_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clause_start(clause_start), .kc_mode(kc_mode),
    .loop_counter_index(loop_counter_index), .result_valid(result_valid), .result(result),
    .grp_valid(grp_valid), .grp(grp), .previous_result_vector(pv));
  agoa_seq_model agoa_seq_model_i (.pclk(pclk), .presetn(presetn), .cl_req(cl_req),
    .kc_req(kc_req), .lp_req(lp_req), .grp_valid(grp_valid), .clause_start(clause_start),
    .kc_mode(kc_mode), .loop_counter_index(loop_counter_index),
    .result_valid(result_valid), .result(result));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, g, x);
    end
  endtask : chk
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    chk(r, x);
  endtask : rd
  // one slot is a low dword then a pushing high dword
  task automatic push(input logic [63:0] s);
    apb(1'b1, agoa_pkg::OFF_SLOT_LO, s[31:0]);
    apb(1'b1, agoa_pkg::OFF_SLOT_HI, s[63:32]);
  endtask : push
  task automatic wgrp();
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (grp_valid === 1'b1) break;
    end
  endtask : wgrp
  function automatic logic [63:0] ins(logic [8:0] s, logic rl, logic [1:0] el, logic [9:0] op,
    logic lst, logic [6:0] dr, logic dl, logic [1:0] de);
    logic [63:0] i;
    i = 64'h0000000000000000;
    i[agoa_pkg::SRC_SEL_LSB[0] +: 9] = s;
    i[agoa_pkg::SOURCE_RELATIVE_FLAG_BIT[0]] = rl;
    i[agoa_pkg::SRC_ELEM_LSB[0] +: 2] = el;
    i[agoa_pkg::IDX_MODE_LSB +: 3] = 3'h4; // loop index only
    i[agoa_pkg::LAST_BIT] = lst;
    i[agoa_pkg::OPC_MSB -: 10] = op;
    i[agoa_pkg::DST_REG_LSB +: 7] = dr;
    i[agoa_pkg::DEST_RELATIVE_FLAG_BIT] = dl;
    i[agoa_pkg::DST_ELEM_LSB +: 2] = de;
    return i;
  endfunction : ins
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(agoa_pkg::OFF_CTRL, 32'h00000080);
    apb(1'b0, 8'h40, 32'h00000000);
    chk({e, r}, 64'h0000000100000000);
    apb(1'b1, agoa_pkg::OFF_CTRL, 32'h00000410);
    push(ins(agoa_pkg::SEL_LIT, 1'b0, 2'h2, 10'h2A0, 1'b0, 7'h03, 1'b0, 2'h1));
    push(ins(9'h07C, 1'b0, 2'h0, 10'h005, 1'b0, 7'h03, 1'b0, 2'h2));
    push(ins(9'h1FF, 1'b1, 2'h0, 10'h005, 1'b1, 7'h0F, 1'b1, 2'h0));
    push(64'h2222222211111111);
    push(64'h4444444433333333);
    wgrp();
    chk(grp.slots, 5);
    chk(grp.chan[1].op3, 1);
    chk(grp.chan[1].opcode, 10'h2A0);
    chk(grp.chan[0].op3, 0);
    chk({grp.chan[3].valid, grp.chan[3].opnd[0].kind}, agoa_pkg::OK_OTHER);
    chk(grp.literal[0], 32'h11111111);
    chk(grp.literal[2], 32'h33333333);
    chk(grp.literal[3], 32'h44444444);
    chk(grp.chan[1].opnd[0].kind, agoa_pkg::OK_LIT);
    chk(grp.chan[2].opnd[0].kind, agoa_pkg::OK_TEMP);
    chk(grp.chan[0].opnd[0].act, agoa_pkg::ACT_NAN);
    chk(grp.chan[0].opnd[3].act, agoa_pkg::ACT_SUPPRESS);
    rd(agoa_pkg::OFF_PREV, 32'h000000A0);
    rd(8'h14, 32'h000000A1);
    rd(8'h1C, 32'h00000000);
    apb(1'b1, agoa_pkg::OFF_CTRL, 32'h00010410);
    // both lock modes against the same relative cache read
    for (int k = 1; k < 3; k++) begin
      kc_req <= agoa_pkg::agoa_kc_t'(k);
      push(ins(9'h00A, 1'b1, 2'h0, 10'h005, 1'b0, 7'h0F, 1'b1, 2'h0));
      push(ins(9'h08F, 1'b1, 2'h0, 10'h005, 1'b1, 7'h01, 1'b0, 2'h1));
      wgrp();
      chk(grp.chan[1].opnd[0].act, k == 1 ? agoa_pkg::ACT_NAN : agoa_pkg::ACT_NORMAL);
      chk(grp.chan[0].opnd[0].act, agoa_pkg::ACT_REG0);
      chk(grp.chan[0].opnd[3].act, agoa_pkg::ACT_REG0);
      chk(grp.slots, 2);
    end
    rd(agoa_pkg::OFF_PREV, 32'h000000A0);
    chk(pv[1:0], 64'h000000A1000000A0);
    chk(pv[3:2], 64'h0000000000000000);
    // a second x instruction replaces the first and flags the duplicate
    push(ins(9'h001, 1'b0, 2'h0, 10'h005, 1'b0, 7'h02, 1'b0, 2'h0));
    push(ins(9'h002, 1'b0, 2'h0, agoa_pkg::LOAD_INDEX_OPC, 1'b1, 7'h01, 1'b0, 2'h0));
    wgrp();
    chk({grp.chan[0].load_index, grp.slots}, 4'h9);
    rd(agoa_pkg::OFF_AIDX, 32'h000000A0);
    rd(agoa_pkg::OFF_STATUS, 32'h00000109);
    apb(1'b1, agoa_pkg::OFF_STATUS, 32'h00000100);
    // index-x relative read lands past the declared registers
    push(ins(9'h005, 1'b1, 2'h0, 10'h005, 1'b1, 7'h01, 1'b0, 2'h2) &
      ~(64'h7 << agoa_pkg::IDX_MODE_LSB));
    wgrp();
    chk(grp.chan[2].opnd[0].act, agoa_pkg::ACT_REG0);
    rd(agoa_pkg::OFF_STATUS, 32'h00000009);
    cl_req <= 1'b1;
    @(posedge pclk);
    cl_req <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(agoa_pkg::OFF_PREV, 32'h00000000);
    rd(agoa_pkg::OFF_AIDX, 32'h00000000);
    rd(agoa_pkg::OFF_STATUS, 32'h00000001);
    print_verdict();
  end
endmodule : tb_top
